// [rtl/phy_test_pkg.sv]
// Package: register offsets, field positions, reset values and timing for the test control bank.
// Assumes a 100 MHz core clock and a 5-bit management register address.
package phy_test_pkg;

  localparam logic [4:0]  ADDR_DRV_TEST     = 5'h1B;
  localparam logic [4:0]  ADDR_CTRL_SECOND  = 5'h1C;
  localparam logic [4:0]  BCAST_PHY_ADDR    = 5'h1F;

  // First register field positions
  localparam int TALLY_LSB       = 8;
  localparam int RSVD7_BIT       = 7;
  localparam int MCLK_FORCE_BIT  = 6;
  localparam int CONT_BIT        = 5;
  localparam int PATEN_BIT       = 4;
  localparam int PULLUP_BIT      = 3;
  localparam int GAP_BIT         = 2;

  // Second register field positions
  localparam int SYNC_BIT        = 13;
  localparam int AUXRX_BIT       = 12;
  localparam int BCAST_BIT       = 11;
  localparam int LEGACY_BIT      = 10;
  localparam int SRST_BIT        = 9;
  localparam int AUXDIS_BIT      = 1;
  localparam int RSVD0_BIT       = 0;

  localparam logic [15:0] DRV_TEST_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_SECOND_RESET = 16'h0000;
  localparam logic [15:0] CTRL_SECOND_WMASK = 16'h3E03;
  localparam logic [7:0]  TALLY_MAX         = 8'hFF;

  // Pattern select codes
  typedef enum logic [1:0] {
    PAT_DATA_A  = 2'b00,
    PAT_DATA_B  = 2'b01,
    PAT_LINK    = 2'b10,
    PAT_ONES    = 2'b11
  } pattern_t;

  // Timing
  localparam int CLK_MHZ          = 100;
  localparam int GAP_LONG_US      = 15;
  localparam int GAP_SHORT_US     = 10;
  localparam int GAP_LONG_CYC     = GAP_LONG_US * CLK_MHZ;
  localparam int GAP_SHORT_CYC    = GAP_SHORT_US * CLK_MHZ;
  localparam int SRST_HOLD_CYC    = 16;

endpackage

// [rtl/phy_test_sync_if.sv]
// Interface: synchronised selftest and link-clock event pulses between top and sampler.
// Assumes one core clock shared by both ends.
interface phy_test_sync_if;
  logic start_pulse;
  logic err_pulse;
  logic link_rise;
  modport producer (output start_pulse, output err_pulse, output link_rise);
  modport consumer (input start_pulse, input err_pulse, input link_rise);
endinterface

// [rtl/phy_test_sampler.sv]
// Sampler: two-flop synchronisers and edge detectors for outside event strobes.
// Assumes raw inputs come from other clock domains (link clock, test engine).
module phy_test_sampler (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         start_raw_i,
  input  wire logic         err_raw_i,
  input  wire logic         link_clk_raw_i,
  phy_test_sync_if.producer ev
);

  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] s1_next;
  logic [2:0] s2_next;
  logic [2:0] s3_next;

  // Next values of the synchroniser chain
  always_comb begin
    s1_next = {link_clk_raw_i, err_raw_i, start_raw_i};
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  // Register the chain
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  // Rising edges of the second stage only
  assign ev.start_pulse = s2_reg[0] & ~s3_reg[0];
  assign ev.err_pulse   = s2_reg[1] & ~s3_reg[1];
  assign ev.link_rise   = s2_reg[2] & ~s3_reg[2];

endmodule

// [rtl/phy_test_control_regs.sv]
// Top: the two test/extended control registers of a 10/100 transceiver and the
// controls they drive. Assumes a management frame engine presents decoded accesses
// on the same clock; strobes from the selftest engine and the link clock are async.
////////////////////////////////////////////////////////////////////////////////
//
// Contract
// - Read-only 8-bit error tally in 15:8
// - Tally clears when selftest restarts
// - Tally saturates at FF, never wraps
// - Clock force bit drives TX and RX clocks
// - Continuous bit makes gapless pseudorandom transmit
// - Pattern select chooses driver test output
// - Gap select: 15 us set, 10 us clear
// - Pullup bit; only hard reset clears it (here a write of 0 also clears it)
// - Reserved second-register fields read zero (here bit 0 reads back as written)
// - Sync enable plus conditions: rx-clocked transmit
// - Otherwise transmit from local reference
// - Rx source at 100M puts rx on aux
// - Else aux output carries reference clock
// - Broadcast enable accepts writes to address 1F
// - Legacy mode reorders pins, enables aux output
// - Soft reset resets logic, keeps registers
// - Aux disable from strap, turns pin off
module phy_test_control_regs (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        WR_EN_I,
  input  wire logic        RD_EN_I,
  input  wire logic [4:0]  PHY_ADDR_I,
  input  wire logic [4:0]  LOCAL_ADDR_I,
  input  wire logic [4:0]  REG_ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        AUX_DIS_STRAP_I,
  input  wire logic        SPEED_100_I,
  input  wire logic        MAC_MII_OR_RMII_MASTER_I,
  input  wire logic        SELFTEST_START_I,
  input  wire logic        SELFTEST_ERR_I,
  input  wire logic        LINK_CLK_I,
  output logic [15:0]      RDATA_O,
  output logic             WR_ACCEPT_O,
  output logic             MCLK_FORCE_O,
  output logic             SELFTEST_CONT_O,
  output logic             PAT_ONES_O,
  output logic             PAT_LINK_O,
  output logic             PAT_DATA_O,
  output logic             PAT_END_B_O,
  output logic             PAT_GAP_ACTIVE_O,
  output logic             PULLUP_EN_O,
  output logic             TX_FROM_RX_CLK_O,
  output logic             AUX_FROM_RX_O,
  output logic             AUX_OUT_EN_O,
  output logic             LEGACY_PINOUT_O,
  output logic             LOGIC_RST_N_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_n;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Event sampling
  phy_test_sync_if ev ();

  phy_test_sampler u_sampler (
    .clk_i          (CLK_I),
    .rst_n_i        (rst_n),
    .start_raw_i    (SELFTEST_START_I),
    .err_raw_i      (SELFTEST_ERR_I),
    .link_clk_raw_i (LINK_CLK_I),
    .ev             (ev.producer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] drv_test_selftest_ext_reg;
  logic [15:0] drv_test_selftest_ext_next;
  logic [15:0] phy_control_second_reg;
  logic [15:0] phy_control_second_next;
  logic        strap_done_reg;
  logic        strap_done_next;
  logic [4:0]  srst_cnt_reg;
  logic [4:0]  srst_cnt_next;
  logic        addr_ok;
  logic        wr_hit_a;
  logic        wr_hit_b;
  logic        srst_busy;
  logic [7:0]  tally;

  assign tally     = drv_test_selftest_ext_reg[15:8];
  assign srst_busy = srst_cnt_reg != 5'h00;
  // Own address, or the broadcast address when enabled
  assign addr_ok   = (PHY_ADDR_I == LOCAL_ADDR_I) ||
                     (phy_control_second_reg[phy_test_pkg::BCAST_BIT] &&
                      PHY_ADDR_I == phy_test_pkg::BCAST_PHY_ADDR);
  assign wr_hit_a  = WR_EN_I && addr_ok && REG_ADDR_I == phy_test_pkg::ADDR_DRV_TEST;
  assign wr_hit_b  = WR_EN_I && addr_ok && REG_ADDR_I == phy_test_pkg::ADDR_CTRL_SECOND;

  // Next values of the register bank
  always_comb begin
    drv_test_selftest_ext_next = drv_test_selftest_ext_reg;
    phy_control_second_next    = phy_control_second_reg;
    strap_done_next            = 1'b1;
    srst_cnt_next              = srst_cnt_reg;
    if (wr_hit_a) begin
      // Writable low byte; bit 7 kept as written
      drv_test_selftest_ext_next[7:0] = WDATA_I[7:0];
    end
    if (ev.start_pulse) begin
      drv_test_selftest_ext_next[15:8] = 8'h00;
    end else if (ev.err_pulse && tally != phy_test_pkg::TALLY_MAX) begin
      drv_test_selftest_ext_next[15:8] = tally + 8'h01;
    end
    if (wr_hit_b) begin
      phy_control_second_next = WDATA_I & phy_test_pkg::CTRL_SECOND_WMASK;
    end
    if (!strap_done_reg) begin
      phy_control_second_next[phy_test_pkg::AUXDIS_BIT] = AUX_DIS_STRAP_I;
    end
    if (srst_busy) begin
      srst_cnt_next = srst_cnt_reg - 5'h01;
      phy_control_second_next[phy_test_pkg::SRST_BIT] = 1'b1;
    end else if (phy_control_second_next[phy_test_pkg::SRST_BIT]) begin
      srst_cnt_next = 5'(phy_test_pkg::SRST_HOLD_CYC);
    end
    if (srst_busy && srst_cnt_reg == 5'h01) begin
      phy_control_second_next[phy_test_pkg::SRST_BIT] = 1'b0;
    end
  end

  // Register bank; only hard reset reaches it, soft reset leaves it intact
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      drv_test_selftest_ext_reg <= phy_test_pkg::DRV_TEST_RESET;
      phy_control_second_reg    <= phy_test_pkg::CTRL_SECOND_RESET;
      strap_done_reg            <= 1'b0;
      srst_cnt_reg              <= 5'h00;
    end else begin
      drv_test_selftest_ext_reg <= drv_test_selftest_ext_next;
      phy_control_second_reg    <= phy_control_second_next;
      strap_done_reg            <= strap_done_next;
      srst_cnt_reg              <= srst_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern gap timer, counts microseconds worth of core cycles
  logic [10:0] gap_cnt_reg;
  logic [10:0] gap_cnt_next;
  logic        gap_active_next;
  logic        gap_active_reg;
  logic        pat_en;
  logic [1:0]  pat_sel;

  assign pat_en  = drv_test_selftest_ext_reg[phy_test_pkg::PATEN_BIT];
  assign pat_sel = drv_test_selftest_ext_reg[1:0];

  // Gap starts at a link-clock rising edge once the last gap has run out, except in the all-ones pattern
  always_comb begin
    gap_cnt_next    = gap_cnt_reg;
    gap_active_next = gap_cnt_reg != 11'h000;
    if (!pat_en || srst_busy) begin
      gap_cnt_next    = 11'h000;
      gap_active_next = 1'b0;
    end else if (gap_cnt_reg != 11'h000) begin
      gap_cnt_next = gap_cnt_reg - 11'h001;
    end else if (ev.link_rise && pat_sel != phy_test_pkg::PAT_ONES) begin
      gap_cnt_next = drv_test_selftest_ext_reg[phy_test_pkg::GAP_BIT] ?
                     11'(phy_test_pkg::GAP_LONG_CYC) :
                     11'(phy_test_pkg::GAP_SHORT_CYC);
      gap_active_next = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt_reg    <= 11'h000;
      gap_active_reg <= 1'b0;
    end else begin
      gap_cnt_reg    <= gap_cnt_next;
      gap_active_reg <= gap_active_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered control outputs
  logic [14:0] ctl_next;
  logic [14:0] ctl_reg;
  logic        sync_ok;
  logic        aux_rx;
  logic        aux_en;

  assign sync_ok = phy_control_second_reg[phy_test_pkg::SYNC_BIT] && SPEED_100_I &&
                   MAC_MII_OR_RMII_MASTER_I;
  assign aux_rx  = phy_control_second_reg[phy_test_pkg::AUXRX_BIT] && SPEED_100_I;
  // Legacy pinout switches the aux output on even when the disable bit is set
  assign aux_en  = !phy_control_second_reg[phy_test_pkg::AUXDIS_BIT] ||
                   phy_control_second_reg[phy_test_pkg::LEGACY_BIT];

  // Decode of the control fields
  always_comb begin
    ctl_next     = 15'h0000;
    ctl_next[0]  = drv_test_selftest_ext_reg[phy_test_pkg::MCLK_FORCE_BIT];
    ctl_next[1]  = drv_test_selftest_ext_reg[phy_test_pkg::CONT_BIT];
    ctl_next[2]  = pat_en && pat_sel == phy_test_pkg::PAT_ONES;
    ctl_next[3]  = pat_en && pat_sel == phy_test_pkg::PAT_LINK;
    ctl_next[4]  = pat_en && !pat_sel[1];
    ctl_next[5]  = pat_en && pat_sel == phy_test_pkg::PAT_DATA_B;
    ctl_next[6]  = gap_active_reg;
    ctl_next[7]  = drv_test_selftest_ext_reg[phy_test_pkg::PULLUP_BIT];
    ctl_next[8]  = sync_ok;
    ctl_next[9]  = aux_rx;
    ctl_next[10] = aux_en;
    ctl_next[11] = phy_control_second_reg[phy_test_pkg::LEGACY_BIT];
    ctl_next[12] = !srst_busy;
    ctl_next[13] = wr_hit_a || wr_hit_b;
    ctl_next[14] = 1'b0;
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= 15'h0000;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign MCLK_FORCE_O     = ctl_reg[0];
  assign SELFTEST_CONT_O  = ctl_reg[1];
  assign PAT_ONES_O       = ctl_reg[2];
  assign PAT_LINK_O       = ctl_reg[3];
  assign PAT_DATA_O       = ctl_reg[4];
  assign PAT_END_B_O      = ctl_reg[5];
  assign PAT_GAP_ACTIVE_O = ctl_reg[6];
  assign PULLUP_EN_O      = ctl_reg[7];
  assign TX_FROM_RX_CLK_O = ctl_reg[8];
  assign AUX_FROM_RX_O    = ctl_reg[9];
  assign AUX_OUT_EN_O     = ctl_reg[10];
  assign LEGACY_PINOUT_O  = ctl_reg[11];
  assign LOGIC_RST_N_O    = ctl_reg[12];
  assign WR_ACCEPT_O      = ctl_reg[13];

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered
  logic [15:0] rdata_next;
  logic [15:0] rdata_reg;

  always_comb begin
    rdata_next = 16'h0000;
    if (RD_EN_I && REG_ADDR_I == phy_test_pkg::ADDR_DRV_TEST) begin
      rdata_next = drv_test_selftest_ext_reg;
    end else if (RD_EN_I && REG_ADDR_I == phy_test_pkg::ADDR_CTRL_SECOND) begin
      rdata_next = phy_control_second_reg & phy_test_pkg::CTRL_SECOND_WMASK;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign RDATA_O = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_tally_sat: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (tally == 8'hFF && !ev.start_pulse) |=> tally == 8'hFF)
    else $error("tally left saturation");
  chk_tally_clear: assert property (@(posedge CLK_I) disable iff (!rst_n)
    ev.start_pulse |=> tally == 8'h00)
    else $error("tally not cleared on restart");
  chk_tally_incr: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (ev.err_pulse && !ev.start_pulse && tally != 8'hFF) |=> tally == $past(tally) + 8'h01)
    else $error("tally did not count error");
  chk_rsvd_zero: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (phy_control_second_reg & ~phy_test_pkg::CTRL_SECOND_WMASK) == 16'h0000)
    else $error("reserved bits set");
  chk_srst_clear: assert property (@(posedge CLK_I) disable iff (!rst_n)
    $rose(srst_busy) |-> ##[1:20] !phy_control_second_reg[phy_test_pkg::SRST_BIT])
    else $error("soft reset never cleared");
  chk_srst_keep: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (srst_busy && !wr_hit_a) |=>
      drv_test_selftest_ext_reg[7:0] == $past(drv_test_selftest_ext_reg[7:0]))
    else $error("soft reset changed registers");
  chk_sync_sel: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (phy_control_second_reg[phy_test_pkg::SYNC_BIT] && SPEED_100_I &&
     MAC_MII_OR_RMII_MASTER_I) |=> TX_FROM_RX_CLK_O)
    else $error("transmit not rx-clocked");
  chk_aux_ref: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (!phy_control_second_reg[phy_test_pkg::AUXRX_BIT] || !SPEED_100_I) |=> !AUX_FROM_RX_O)
    else $error("aux not on reference");
  chk_legacy_aux: assert property (@(posedge CLK_I) disable iff (!rst_n)
    phy_control_second_reg[phy_test_pkg::LEGACY_BIT] |=> AUX_OUT_EN_O)
    else $error("legacy mode left aux output off");
  chk_bcast_wr: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (WR_EN_I && PHY_ADDR_I == 5'h1F && phy_control_second_reg[phy_test_pkg::BCAST_BIT]
     && REG_ADDR_I == phy_test_pkg::ADDR_DRV_TEST) |=> WR_ACCEPT_O)
    else $error("broadcast write refused");
  cov_saturate: cover property (@(posedge CLK_I) disable iff (!rst_n) tally == 8'hFF);
  cov_srst: cover property (@(posedge CLK_I) disable iff (!rst_n) $fell(srst_busy));
  cov_gap: cover property (@(posedge CLK_I) disable iff (!rst_n) $rose(gap_active_reg));

endmodule

// [dv/mgmt_master_model.sv]
// Management master model: issues single-cycle register reads and writes.
// Assumes the block takes a request on the rising edge of clk_i after it is raised.
module mgmt_master_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        wr_accept_i,
  output logic             wr_en_o,
  output logic             rd_en_o,
  output logic [4:0]       phy_addr_o,
  output logic [4:0]       reg_addr_o,
  output logic [15:0]      wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    phy_addr_o = 5'h00;
    reg_addr_o = 5'h00;
    wdata_o = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One write; acc holds the accept pulse seen after the taking edge
  task automatic write_reg(input logic [4:0] pa, input logic [4:0] ra,
                           input logic [15:0] d, output logic acc);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    phy_addr_o <= pa;
    reg_addr_o <= ra;
    wdata_o <= d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    reg_addr_o <= ~ra;  // Register address and data lines show the inverse, not stale data; phy address stays as driven
    wdata_o <= ~d;
    #1 acc = wr_accept_i;
  endtask

  // One read; data is taken in the cycle after the request
  task automatic read_reg(input logic [4:0] ra, output logic [15:0] d);
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    reg_addr_o <= ra;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    reg_addr_o <= ~ra;
    #1 d = rdata_i;
  endtask
endmodule

// [dv/phy_test_control_regs_test.sv]
// Testbench for the test control register bank: reset values, a table of register writes,
// then broadcast, error tally, soft reset, pattern gap and hard reset tests.
// Assumes mgmt_master_model as the management side and a 100 MHz core clock.
module phy_test_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0]  ra;
    logic [15:0] wd;
    logic [1:0]  spd_mac;
    logic [15:0] rd;
    logic [10:0] outs;
  } row_t;
  localparam logic [4:0] LA = 5'h05;
  localparam logic [4:0] DA = phy_test_pkg::ADDR_DRV_TEST;
  localparam logic [4:0] CA = phy_test_pkg::ADDR_CTRL_SECOND;
  localparam int GS = phy_test_pkg::GAP_SHORT_CYC;
  localparam int GL = phy_test_pkg::GAP_LONG_CYC;
  logic        clk, rst_n, strap, spd, mac, st_start, st_err, link_clk, acc;
  logic        wr_en, rd_en;
  logic [4:0]  pa, ra;
  logic [15:0] wd, rdata, rd;
  wire  [10:0] outs;
  wire         wacc, gap, lrst_n;
  int          n_mismatch, cmp_count, n;
  row_t        rows [10];

  phy_test_control_regs i_dut (
    .CLK_I(clk), .RST_N_I(rst_n), .WR_EN_I(wr_en), .RD_EN_I(rd_en),
    .PHY_ADDR_I(pa), .LOCAL_ADDR_I(LA), .REG_ADDR_I(ra), .WDATA_I(wd),
    .AUX_DIS_STRAP_I(strap), .SPEED_100_I(spd), .MAC_MII_OR_RMII_MASTER_I(mac),
    .SELFTEST_START_I(st_start), .SELFTEST_ERR_I(st_err), .LINK_CLK_I(link_clk),
    .RDATA_O(rdata), .WR_ACCEPT_O(wacc), .MCLK_FORCE_O(outs[10]),
    .SELFTEST_CONT_O(outs[9]), .PAT_ONES_O(outs[8]), .PAT_LINK_O(outs[7]),
    .PAT_DATA_O(outs[6]), .PAT_END_B_O(outs[5]), .PAT_GAP_ACTIVE_O(gap),
    .PULLUP_EN_O(outs[4]), .TX_FROM_RX_CLK_O(outs[3]), .AUX_FROM_RX_O(outs[2]),
    .AUX_OUT_EN_O(outs[1]), .LEGACY_PINOUT_O(outs[0]), .LOGIC_RST_N_O(lrst_n));

  mgmt_master_model i_mgmt (
    .clk_i(clk), .rdata_i(rdata), .wr_accept_i(wacc), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .phy_addr_o(pa), .reg_addr_o(ra), .wdata_o(wd));

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks and closing
  task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_outs(input string nm, input logic [10:0] e, input logic [10:0] g);
    cmp_word(nm, {5'h00, e}, {5'h00, g});
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    cmp_word(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic end_of_test;
    $display("Counts: %0d comparisons, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Stimulus helpers for the selftest strobes and the link clock
  task automatic start_test;
    @(posedge clk) st_start <= 1'b1;
    repeat (3) @(posedge clk);
    st_start <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic errs(input int k);
    repeat (k) begin
      @(posedge clk) st_err <= 1'b1;
      repeat (2) @(posedge clk);
      st_err <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic gap_len(input logic [15:0] d, output int k);
    i_mgmt.write_reg(LA, DA, d, acc);
    k = 0;
    // One 80 ns link clock pulse, counting over 2000 cycles from its first edge
    for (int j = 0; j < 2000; j++) begin
      @(posedge clk) link_clk <= (j < 8);
      @(negedge clk) k += int'(gap);
    end
  endtask
  task automatic hard_reset;
    @(posedge clk) rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog sized well past the expected run of about 6000 cycles
  initial begin
    #200us;
    n_mismatch++;
    $display("Watchdog expired");
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    strap = 1'b1;
    spd = 1'b1;
    mac = 1'b1;
    st_start = 1'b0;
    st_err = 1'b0;
    link_clk = 1'b0;
    rows = '{'{DA, 16'h0010, 2'b11, 16'h0010, 11'b00001000000},
             '{DA, 16'h0011, 2'b11, 16'h0011, 11'b00001100000},
             '{DA, 16'h0012, 2'b11, 16'h0012, 11'b00010000000},
             '{DA, 16'h0073, 2'b11, 16'h0073, 11'b11100000000},
             '{DA, 16'hFF08, 2'b11, 16'h0008, 11'b00000010000},
             '{CA, 16'hFDFC, 2'b11, 16'h3C00, 11'b00000011111},
             '{CA, 16'hFDFC, 2'b01, 16'h3C00, 11'b00000010011},
             '{CA, 16'hFDFC, 2'b10, 16'h3C00, 11'b00000010111},
             '{CA, 16'h0402, 2'b11, 16'h0402, 11'b00000010011},
             '{CA, 16'h0002, 2'b11, 16'h0002, 11'b00000010000}};
    hard_reset();
    // Reset values and an unmapped read
    i_mgmt.read_reg(DA, rd);
    cmp_word("first reg reset", 16'h0000, rd);
    i_mgmt.read_reg(CA, rd);
    cmp_word("second reg reset", 16'h0002, rd);
    i_mgmt.read_reg(5'h00, rd);
    cmp_word("unmapped read", 16'h0000, rd);
    cmp_outs("controls after reset", 11'h000, outs);
    $display("Test done: reset values");
    // Single manager on this bus, so the pullup row is allowed
    foreach (rows[i]) begin
      @(posedge clk);
      spd <= rows[i].spd_mac[1];
      mac <= rows[i].spd_mac[0];
      i_mgmt.write_reg(LA, rows[i].ra, rows[i].wd, acc);
      cmp_bit("write accept", 1'b1, acc);
      i_mgmt.read_reg(rows[i].ra, rd);
      cmp_word("readback", rows[i].rd, rd);
      repeat (2) @(posedge clk);
      #1 cmp_outs("control outputs", rows[i].outs, outs);
    end
    $display("Test done: register table");
    // Broadcast address refused, then accepted once enabled
    i_mgmt.write_reg(phy_test_pkg::BCAST_PHY_ADDR, DA, 16'h0018, acc);
    cmp_bit("broadcast refused", 1'b0, acc);
    i_mgmt.write_reg(LA, CA, 16'h0802, acc);
    i_mgmt.write_reg(phy_test_pkg::BCAST_PHY_ADDR, DA, 16'h000C, acc);
    cmp_bit("broadcast taken", 1'b1, acc);
    i_mgmt.write_reg(5'h07, DA, 16'h0008, acc);
    cmp_bit("foreign address", 1'b0, acc);
    i_mgmt.read_reg(DA, rd);
    cmp_word("after broadcast", 16'h000C, rd);
    $display("Test done: broadcast");
    // Jabber guard lives outside this block; tally only is exercised
    start_test();
    errs(3);
    i_mgmt.read_reg(DA, rd);
    cmp_word("tally count", 16'h030C, rd);
    errs(260);
    i_mgmt.read_reg(DA, rd);
    cmp_word("tally saturated", 16'hFF0C, rd);
    start_test();
    i_mgmt.read_reg(DA, rd);
    cmp_word("tally restart", 16'h000C, rd);
    $display("Test done: error tally");
    // Soft reset keeps registers and clears itself
    i_mgmt.write_reg(LA, CA, 16'h0202, acc);
    i_mgmt.read_reg(CA, rd);
    cmp_word("soft reset busy", 16'h0202, rd);
    cmp_bit("logic reset held", 1'b0, lrst_n);
    repeat (20) @(posedge clk);
    i_mgmt.read_reg(CA, rd);
    cmp_word("soft reset done", 16'h0002, rd);
    i_mgmt.read_reg(DA, rd);
    cmp_word("kept over soft reset", 16'h000C, rd);
    cmp_bit("logic reset gone", 1'b1, lrst_n);
    $display("Test done: soft reset");
    // Gap after one link clock edge
    gap_len(16'h0010, n);
    cmp_bit("short gap", 1'b1, n >= GS - 1 && n <= GS + 1);
    gap_len(16'h001C, n);
    cmp_bit("long gap", 1'b1, n >= GL - 1 && n <= GL + 1);
    $display("Test done: pattern gap");
    // Hard reset clears the pullup; strap low now
    @(posedge clk) strap <= 1'b0;
    hard_reset();
    i_mgmt.read_reg(DA, rd);
    cmp_word("pullup hard reset", 16'h0000, rd);
    i_mgmt.read_reg(CA, rd);
    cmp_word("strap low reset", 16'h0000, rd);
    $display("Test done: hard reset");
    end_of_test();
  end
endmodule
